// >>> tsi_switch_memory.sv
`timescale 1ns/10ps
// ==========================================================
// Timeslot interchange memory, 2048 x 16, eight modes
module tsi_switch_memory
  import tsi_pkg::*;
#(
  parameter int unsigned DEPTH = TSI_DEPTH, // Words of storage
  parameter int unsigned DW = TSI_DW // Word width
)(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, low
  input wire logic i_mode_sel_x, // Mode select, msb
  input wire logic i_mode_sel_y, // Mode select, middle
  input wire logic i_mode_sel_z, // Mode select, lsb
  input wire logic i_frame_pulse_b, // Frame pulse, low
  input wire logic [DW-1:0] i_data, // Input data bus pin level
  input wire logic [15:0] i_addr, // External address bus
  input wire logic i_read_write_select, // High read, low write
  input wire logic i_chip_select_b, // Chip select, low
  input wire logic i_data_strobe_b, // Processor strobe, low
  output logic [DW-1:0] o_data, // Output data bus
  output logic [DW-1:0] o_up_data, // Processor read data
  output logic o_up_data_oe, // Drive input bus back
  output logic o_data_ack_out_b, // Acknowledge, low
  output logic o_change_flag_b // Change detect, low
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH != TSI_DEPTH || DW < 1) begin
      $error("tsi_switch_memory: DEPTH must be 2048 and DW positive");
    end
  end

  // ==========================================================
  // Mode decode
  tsi_mode_t mode;
  assign mode = tsi_mode_t'({i_mode_sel_x, i_mode_sel_y, i_mode_sel_z});
  wire conn_mode = (mode == TSI_CONN_HALF) || (mode == TSI_CONN_FULL);
  wire frame = !i_frame_pulse_b;

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] cnt;
  logic half_ph;
  logic buf_sel;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] next_data;
  logic rd_en;

  // ==========================================================
  // Internal 11-bit counter
  // frame clears, wraps at 2047
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= '0;
      half_ph <= 1'b0;
    end else if (frame) begin
      cnt <= '0;
      half_ph <= 1'b0;
    end else if (mode == TSI_CONN_HALF) begin
      // two clocks per word, so 1024 at 16.384 MHz and 8 kHz
      half_ph <= !half_ph;
      if (half_ph) begin
        cnt <= AW'(cnt + 1'b1);
      end
    end else begin
      // scalable mode counts whatever the frame length
      cnt <= (cnt == AW'(TSI_CNT_MAX)) ? '0 : AW'(cnt + 1'b1);
    end
  end

  // Buffer half toggles each frame; harmless in other modes
  // halves swap every frame
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      buf_sel <= 1'b0;
    end else if (frame) begin
      buf_sel <= !buf_sel;
    end
  end

  // ==========================================================
  // Processor port: strobe handshake
  tsi_up_state_t up_st;
  logic [1:0] up_wait;
  logic ds_q;
  logic up_wr;
  wire up_sel = !i_chip_select_b && !i_data_strobe_b;
  wire ds_fall = ds_q && !i_data_strobe_b;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ds_q <= 1'b1;
    end else begin
      ds_q <= i_data_strobe_b;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      up_st <= TSI_UP_IDLE;
      up_wait <= '0;
      o_data_ack_out_b <= 1'b1;
      o_up_data <= TSI_DATA_RST;
      o_up_data_oe <= 1'b0;
      up_wr <= 1'b0;
    end else begin
      up_wr <= 1'b0;
      unique case (up_st)
        TSI_UP_IDLE: begin
          o_data_ack_out_b <= 1'b1;
          o_up_data_oe <= 1'b0;
          // only the connect modes serve the processor
          if (conn_mode && up_sel) begin
            up_wait <= 2'h1;
            up_st <= TSI_UP_WAIT;
          end
        end
        TSI_UP_WAIT: begin
          if (i_data_strobe_b) begin
            up_st <= TSI_UP_IDLE;
          end else if (up_wait == TSI_WR_LATCH_CYC) begin
            up_wr <= !i_read_write_select;
            o_up_data <= mem[i_addr[AW-1:0]];
            o_up_data_oe <= i_read_write_select;
            o_data_ack_out_b <= 1'b0;
            up_st <= TSI_UP_ACK;
          end else begin
            up_wait <= 2'(up_wait + 1'b1);
          end
        end
        TSI_UP_ACK: begin
          if (i_data_strobe_b) begin
            o_data_ack_out_b <= 1'b1;
            o_up_data_oe <= 1'b0;
            up_st <= TSI_UP_IDLE;
          end
        end
        default: begin
          up_st <= TSI_UP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Delay line length
  logic [AW-1:0] dly_addr;
  logic [AW-1:0] dly_ptr;
  // latch on strobe fall with chip select low
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dly_addr <= '0;
    end else if (mode == TSI_DELAY_LINE && ds_fall && !i_chip_select_b) begin
      dly_addr <= i_addr[AW-1:0];
    end
  end

  // circular pointer over addr+1 slots; both rings give 2*addr+2 stages, max 4096
  // Two words per slot: one in the main ring, one in the second ring
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dly_ptr <= '0;
    end else if (dly_ptr >= dly_addr) begin
      dly_ptr <= '0;
    end else begin
      dly_ptr <= AW'(dly_ptr + 1'b1);
    end
  end

  // ==========================================================
  // Datapath address and write select
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic dm_lo;
  // Per-frame half-select bit (buf_sel) for double buffer; lets mode 000/001 mix
  always_comb begin
    wr_en = 1'b0;
    wr_addr = cnt;
    wr_data = i_data;
    rd_en = 1'b0;
    rd_addr = i_addr[AW-1:0];
    dm_lo = 1'b0;
    unique case (mode)
      TSI_MIN_DELAY, TSI_SCALABLE: begin
        wr_en = 1'b1;
        rd_en = 1'b1;
      end
      TSI_DOUBLE_BUF: begin
        // write one half, read other half
        wr_en = 1'b1;
        rd_en = 1'b1;
        wr_addr = {buf_sel, cnt[AW-2:0]};
        rd_addr = {!buf_sel, i_addr[AW-2:0]};
      end
      TSI_CONN_HALF, TSI_CONN_FULL: begin
        wr_en = up_wr;
        wr_addr = i_addr[AW-1:0];
        rd_en = 1'b1;
        rd_addr = cnt;
      end
      TSI_SEQUENTIAL: begin
        wr_en = !i_read_write_select;
        rd_en = i_read_write_select;
        rd_addr = cnt;
      end
      TSI_RANDOM: begin
        wr_en = !i_read_write_select;
        wr_addr = i_addr[AW-1:0];
        rd_en = i_read_write_select;
      end
      TSI_DELAY_LINE: begin
        wr_en = 1'b1;
        wr_addr = dly_ptr;
        rd_en = 1'b1;
        rd_addr = dly_ptr;
        dm_lo = 1'b1;
      end
    endcase
  end

  // Delay line: two rings of addr+1 slots give 2*(addr+1) cycles
  logic [DW-1:0] dly_mid [DEPTH];

  // storage acts on rising edges only
  // No extra pipe stage in the delay path, or the lag grows by one
  always_ff @(posedge i_sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= dm_lo ? dly_mid[dly_ptr] : wr_data;
    end
  end

  // Second ring doubles the depth for the delay line
  always_ff @(posedge i_sys_clk) begin
    if (dm_lo) begin
      dly_mid[dly_ptr] <= i_data;
    end
  end

  // ==========================================================
  // Output register
  // cycles with rd_en low keep the last read word on the bus
  always_comb begin
    next_data = o_data;
    if (rd_en) begin
      next_data = mem[rd_addr];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= TSI_DATA_RST;
    end else begin
      o_data <= next_data;
    end
  end

  // ==========================================================
  // Change detect: set wins over processor clear
  logic crc_hit;
  logic up_wr_frame;
  logic [1:0] wr_hist;
  tsi_crc u_crc (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_frame(frame),
    .i_valid(rd_en && !dm_lo),
    .i_word(mem[rd_addr]),
    .o_changed(crc_hit)
  );

  // Processor writes mask the next two comparisons, they are not corruption
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      up_wr_frame <= 1'b0;
    end else if (frame) begin
      up_wr_frame <= up_wr;
    end else if (up_wr) begin
      up_wr_frame <= 1'b1;
    end
  end

  // A write can upset either of the next two comparisons; the result lags the frame
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_hist <= 2'h0;
    end else if (frame) begin
      wr_hist <= {wr_hist[0], up_wr_frame || up_wr};
    end
  end

  // flag low on change, cleared by selected strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_change_flag_b <= 1'b1;
    end else if (crc_hit && wr_hist == 2'h0) begin
      o_change_flag_b <= 1'b0;
    end else if (ds_fall && !i_chip_select_b) begin
      o_change_flag_b <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  property p_ack_release;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (up_st == TSI_UP_ACK && i_data_strobe_b) |=> o_data_ack_out_b;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");

  property p_wr_wait;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (up_st == TSI_UP_IDLE && conn_mode && up_sel) ##1 !i_data_strobe_b [*3]
      |=> !o_data_ack_out_b;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("ack not after three clocks");

  property p_ack_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(o_data_ack_out_b) |-> !i_data_strobe_b;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack without strobe");

  property p_frame_clr;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    frame |=> (cnt == '0);
  endproperty
  a_frame_clr: assert property (p_frame_clr) else $error("counter not cleared");

  property p_wrap;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (mode == TSI_CONN_FULL && cnt == AW'(TSI_CNT_MAX) && !frame) |=> (cnt == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_half;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (mode == TSI_CONN_HALF && !half_ph && !frame) |=> $stable(cnt);
  endproperty
  a_half: assert property (p_half) else $error("half rate counter moved");

  property p_hold_wr;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (mode == TSI_SEQUENTIAL && !i_read_write_select) |=> $stable(o_data);
  endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("output moved on write");

  property p_buf;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    frame |=> (buf_sel != $past(buf_sel));
  endproperty
  a_buf: assert property (p_buf) else $error("halves not swapped");
endmodule : tsi_switch_memory

// >>> tsi_pkg.sv
// Functional notes
// - Double buffer mode splits memory in halves, swapped every frame.
// - One-channel output lag gives channels other than 0 and 1 one frame delay.
// - Aligned frames: output channels 0 and 1 get two-frame delay.
// - Min delay and double buffer selection may change per timeslot.
// - Scalable frame mode accepts any clock and frame rate.
// - Scalable frame mode is not switchable per timeslot.
// - Half rate connect mode gives processor random read and write access.
// - Half rate connect counter advances every two clocks, cleared by frame pulse.
// - Half rate connect yields at most 1024 addresses per 8 kHz frame.
// - Read: strobe low, ack low with valid data, strobe high, ack released.
// - Write: ack about three clocks after strobe falls, write data latched one clock after ack.
// - Full rate connect outputs a word each clock, counter wraps at 2047.
// - Sequential mode addresses from 11-bit counter, wraps at 2047 or frame pulse.
// - Sequential mode reads when read_write_select high, writes when low.
// - During write cycles the output holds the last word read.
// - Random access mode uses external address, read_write_select each clock.
// - Sequential, random and delay modes act on rising clock edges only.
// - Delay line delays each word by twice latched address plus two.
// - Delay line supports delays up to 4096 cycles.
// - Delay address captured on strobe falling edge with chip select low.
// - Three mode_sel pins choose one of eight modes.
// - Per-frame CRC pulls change_flag low; strobe with chip select clears it.
package tsi_pkg;
  // ==========================================================
  // Geometry
  localparam int unsigned TSI_DEPTH = 2048;
  localparam int unsigned TSI_AW = 11;
  localparam int unsigned TSI_DW = 16;
  localparam logic [10:0] TSI_CNT_MAX = 11'h7FF;
  // ==========================================================
  // Processor port timing, CRC and reset constants
  localparam logic [1:0] TSI_WR_LATCH_CYC = 2'h3;
  localparam logic [15:0] TSI_CRC_POLY = 16'h1021;
  localparam logic [15:0] TSI_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] TSI_DATA_RST = 16'h0000;
  // ==========================================================
  // Mode encodings on mode_sel_x/y/z
  typedef enum logic [2:0] {
    TSI_MIN_DELAY = 3'h0,
    TSI_DOUBLE_BUF = 3'h1,
    TSI_CONN_HALF = 3'h2,
    TSI_CONN_FULL = 3'h3,
    TSI_SEQUENTIAL = 3'h4,
    TSI_RANDOM = 3'h5,
    TSI_DELAY_LINE = 3'h6,
    TSI_SCALABLE = 3'h7
  } tsi_mode_t;

  typedef enum logic [1:0] {
    TSI_UP_IDLE,
    TSI_UP_WAIT,
    TSI_UP_ACK
  } tsi_up_state_t;
endpackage : tsi_pkg

// >>> tsi_crc.sv
`timescale 1ns/10ps
// ==========================================================
// Running CRC over the words read each frame; compares frame to frame
module tsi_crc
  import tsi_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, low
  input wire logic i_frame, // Frame boundary pulse
  input wire logic i_valid, // Word sampled this clock
  input wire logic [15:0] i_word, // Word to fold in
  output logic o_changed // One-cycle pulse on mismatch
);
  logic [15:0] acc;
  logic [15:0] last;
  logic have_last;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ TSI_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // Fold words in; on frame, compare with last frame's sum
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc <= TSI_CRC_INIT;
      last <= TSI_CRC_INIT;
      have_last <= 1'b0;
      o_changed <= 1'b0;
    end else if (i_frame) begin
      last <= acc;
      have_last <= 1'b1;
      o_changed <= have_last && (acc != last);
      acc <= TSI_CRC_INIT;
    end else begin
      o_changed <= 1'b0;
      if (i_valid) begin
        acc <= crc_step(acc, i_word);
      end
    end
  end
endmodule : tsi_crc

// >>> tsi_up_model.sv
`timescale 1ns/10ps
// ==========================================================
// Processor side: strobe and acknowledge master, plus stream lines
module tsi_up_model (
  input wire logic i_sys_clk, // System clock
  input wire logic i_ack_b, // Acknowledge from device, low
  input wire logic [15:0] i_bus, // Resolved input data bus
  output logic o_cs_b, // Chip select, low
  output logic o_ds_b, // Data strobe, low
  output logic o_rw, // High read, low write
  output logic [15:0] o_addr, // Address lines
  output logic [15:0] o_data, // Write data
  output logic o_data_oe // High while driving data
);
  // Idle bus at time zero
  initial begin
    o_cs_b = 1'b1;
    o_ds_b = 1'b1;
    o_rw = 1'b1;
    o_addr = 16'h0000;
    o_data = 16'h0000;
    o_data_oe = 1'b0;
  end

  // Stream modes reuse the lines without a strobe; caller sits at an edge
  task automatic set_lines(input logic rw, input logic [15:0] addr);
    o_rw <= rw;
    o_addr <= addr;
  endtask : set_lines

  // One access; waits is -1 when no acknowledge came within limit
  task automatic access(input logic rw, input logic [15:0] addr, input logic [15:0] wdata,
                        input int limit, output logic [15:0] rdata, output int waits);
    int n;
    n = 0;
    rdata = 16'h0000;
    waits = -1;
    @(posedge i_sys_clk);
    o_cs_b <= 1'b0;
    o_ds_b <= 1'b0;
    o_rw <= rw;
    o_addr <= addr;
    o_data <= wdata;
    o_data_oe <= ~rw;
    while (waits < 0 && n < limit) begin
      @(posedge i_sys_clk);
      n++;
      if (i_ack_b === 1'b0) begin
        waits = n;
        rdata = i_bus;
      end
    end
    o_ds_b <= 1'b1;
    n = 0;
    while (i_ack_b !== 1'b1 && n < limit) begin
      @(posedge i_sys_clk);
      n++;
    end
    // Released data shows the inverse so a stale word never passes
    @(posedge i_sys_clk);
    o_cs_b <= 1'b1;
    o_data_oe <= 1'b0;
    o_data <= ~wdata;
  endtask : access
endmodule : tsi_up_model

// >>> tsi_switch_memory_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the switch memory
module tsi_switch_memory_tb
  import tsi_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] mode = 3'h3;
  logic frame_b = 1'b1;
  logic [15:0] tb_din = 16'h0000;
  logic [15:0] o_data, up_data, m_addr, m_data;
  logic up_oe, ack_b, cs_b, ds_b, rw, m_oe, flag_b;
  wire logic [15:0] bus;
  int bad_count = 0;
  int samples_checked = 0;

  // Bus level: device drive wins, then processor, then stream source
  assign bus = up_oe ? up_data : (m_oe ? m_data : tb_din);

  tsi_switch_memory dut (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_mode_sel_x(mode[2]),
    .i_mode_sel_y(mode[1]),
    .i_mode_sel_z(mode[0]),
    .i_frame_pulse_b(frame_b),
    .i_data(bus),
    .i_addr(m_addr),
    .i_read_write_select(rw),
    .i_chip_select_b(cs_b),
    .i_data_strobe_b(ds_b),
    .o_data(o_data),
    .o_up_data(up_data),
    .o_up_data_oe(up_oe),
    .o_data_ack_out_b(ack_b),
    .o_change_flag_b(flag_b)
  );

  tsi_up_model up (
    .i_sys_clk(i_sys_clk),
    .i_ack_b(ack_b),
    .i_bus(bus),
    .o_cs_b(cs_b),
    .o_ds_b(ds_b),
    .o_rw(rw),
    .o_addr(m_addr),
    .o_data(m_data),
    .o_data_oe(m_oe)
  );

  // 250 MHz clock
  always #2 i_sys_clk = ~i_sys_clk;

  // ==========================================================
  // Shared helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic set_mode(input tsi_mode_t m);
    @(posedge i_sys_clk);
    mode <= m;
    repeat (2) @(posedge i_sys_clk);
  endtask : set_mode

  task automatic frame_go();
    @(posedge i_sys_clk);
    frame_b <= 1'b0;
    @(posedge i_sys_clk);
    frame_b <= 1'b1;
  endtask : frame_go

  // Bounded search for a word on the output bus
  task automatic seek(input logic [15:0] v, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 12 && !hit; i++) begin
      @(posedge i_sys_clk);
      #1;
      hit = (o_data === v);
    end
  endtask : seek

  // ==========================================================
  // Scenarios
  task automatic test_connect();
    logic [15:0] rd;
    int w;
    logic hit;
    set_mode(TSI_CONN_FULL);
    check("flag idle", 16'h0001, {15'h0000, flag_b});
    for (int k = 0; k < 9; k++) begin
      up.access(1'b0, (k < 8) ? 16'(k) : 16'h07FF, 16'hC000 + 16'(k), 16, rd, w);
      check("write ack wait", 16'h0001, {15'h0000, (w >= 3 && w <= 6)});
      up.access(1'b1, (k < 8) ? 16'(k) : 16'h07FF, 16'h0000, 16, rd, w);
      check("read back", 16'hC000 + 16'(k), rd);
      check("ack released", 16'h0001, {15'h0000, ack_b});
    end
    frame_go();
    seek(16'hC000, hit);
    check("full frame start", 16'h0001, {15'h0000, hit});
    for (int k = 1; k < 8; k++) begin
      @(posedge i_sys_clk);
      #1;
      check("full sequence", 16'hC000 + 16'(k), o_data);
    end
    repeat (2040) @(posedge i_sys_clk);
    #1;
    check("full last word", 16'hC008, o_data);
    @(posedge i_sys_clk);
    #1;
    check("full wrap", 16'hC000, o_data);
    set_mode(TSI_CONN_HALF);
    frame_go();
    seek(16'hC000, hit);
    check("half frame start", 16'h0001, {15'h0000, hit});
    for (int i = 1; i < 10; i++) begin
      @(posedge i_sys_clk);
      #1;
      check("half sequence", 16'hC000 + 16'(i / 2), o_data);
    end
  endtask : test_connect

  task automatic test_sequential();
    logic [15:0] held;
    logic hit;
    set_mode(TSI_SEQUENTIAL);
    up.set_lines(1'b0, 16'h0000);
    frame_go();
    for (int k = 0; k < 40; k++) begin
      @(posedge i_sys_clk);
      tb_din <= 16'h5000 + 16'(k);
    end
    @(posedge i_sys_clk);
    up.set_lines(1'b1, 16'h0000);
    frame_go();
    hit = 1'b0;
    for (int i = 0; i < 12 && !hit; i++) begin
      @(posedge i_sys_clk);
      #1;
      hit = (o_data[15:8] === 8'h50);
    end
    check("seq found", 16'h0001, {15'h0000, hit});
    held = o_data;
    for (int i = 1; i < 20; i++) begin
      @(posedge i_sys_clk);
      #1;
      check("seq order", held + 16'(i), o_data);
    end
    // Writes must not disturb the last word read
    @(posedge i_sys_clk);
    up.set_lines(1'b0, 16'h0000);
    tb_din <= 16'hFFFF;
    repeat (3) @(posedge i_sys_clk);
    #1;
    held = o_data;
    check("hold is read word", 16'h0050, {8'h00, held[15:8]});
    repeat (4) @(posedge i_sys_clk);
    #1;
    check("hold stable", held, o_data);
  endtask : test_sequential

  task automatic test_random();
    set_mode(TSI_RANDOM);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_sys_clk);
      up.set_lines(1'b0, 16'h0100 + 16'(k) * 16'h0155);
      tb_din <= 16'h3A00 + 16'(k);
    end
    for (int k = 3; k >= 0; k--) begin
      @(posedge i_sys_clk);
      up.set_lines(1'b1, 16'h0100 + 16'(k) * 16'h0155);
      repeat (3) @(posedge i_sys_clk);
      #1;
      check("random read", 16'h3A00 + 16'(k), o_data);
    end
  endtask : test_random

  task automatic test_double();
    set_mode(TSI_DOUBLE_BUF);
    up.set_lines(1'b1, 16'h0003);
    frame_go();
    for (int k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      tb_din <= 16'hD000 + 16'(k);
    end
    frame_go();
    @(posedge i_sys_clk);
    #1;
    check("double read half", 16'hD002, o_data);
    repeat (6) @(posedge i_sys_clk);
    frame_go();
    @(posedge i_sys_clk);
    #1;
    check("double swap", 16'hD007, o_data);
    // Direct modes: written at the counter, read at the address lines
    for (int m = 0; m < 2; m++) begin
      set_mode((m == 0) ? TSI_MIN_DELAY : TSI_SCALABLE);
      tb_din <= 16'hD0A0 + 16'(m);
      frame_go();
      repeat (6) @(posedge i_sys_clk);
      #1;
      check("direct read", 16'hD0A0 + 16'(m), o_data);
    end
  endtask : test_double

  task automatic test_delay();
    logic [15:0] rd;
    logic [15:0] dl [3] = '{16'h0002, 16'h0000, 16'h07FF};
    int w;
    int lag;
    set_mode(TSI_DELAY_LINE);
    for (int j = 0; j < 3; j++) begin
      up.access(1'b1, dl[j], 16'h0000, 8, rd, w);
      check("no ack outside connect", 16'h0001, {15'h0000, (w < 0)});
      check("flag cleared", 16'h0001, {15'h0000, flag_b});
      lag = 2 * int'(dl[j]) + 3;
      for (int k = 0; k < lag + 8; k++) begin
        @(posedge i_sys_clk);
        tb_din <= 16'h7000 + 16'(k);
        #1;
        if (k >= lag) begin
          check("delay line", 16'h7000 + 16'(k - lag), o_data);
        end
      end
    end
  endtask : test_delay

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    test_connect();
    $display("test connect done");
    test_sequential();
    $display("test sequential done");
    test_random();
    $display("test random done");
    test_double();
    $display("test double done");
    test_delay();
    $display("test delay done");
    complete_run();
  end

  // Tests need roughly 6600 cycles; allow plenty of margin
  initial begin
    #(30000 * 4);
    bad_count++;
    complete_run();
  end
endmodule : tsi_switch_memory_tb
